// *** common/timer_pkg.sv ***
// Package with register map, field layouts and reset values of the capture/compare timer
package timer_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [4:0] OFF_CAPTURE_A = 5'h00;
  localparam logic [4:0] OFF_CAPTURE_B = 5'h04;
  localparam logic [4:0] OFF_COMPARE_A = 5'h08;
  localparam logic [4:0] OFF_COMPARE_B = 5'h0C;
  localparam logic [4:0] OFF_COUNTER = 5'h10;
  localparam logic [4:0] OFF_CONTROL_ONE = 5'h14;
  localparam logic [4:0] OFF_CONTROL_TWO = 5'h18;
  localparam logic [4:0] OFF_EVENT_FLAGS = 5'h1C;

  // ****************************************************************
  // Reset and special values
  // ****************************************************************
  localparam logic [15:0] COMPARE_RESET = 16'h8000;
  localparam logic [15:0] COUNTER_RELOAD = 16'hFFFC;
  localparam logic [15:0] COUNTER_MAX = 16'hFFFF;
  localparam logic [15:0] COUNTER_ZERO = 16'h0000;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [15:0] CAPTURE_RESET = 16'h0000;
  localparam logic [7:0] PRESCALE_RESET = 8'h00;

  // ****************************************************************
  // Field layouts
  // ****************************************************************
  typedef struct packed {
    logic enable;
    logic pulse_measure_mode;
    logic [1:0] reserved;
    logic force_level_b;
    logic force_level_a;
    logic output_level_b;
    logic output_level_a;
    logic compare_b_pin_dedicate;
    logic compare_a_pin_dedicate;
    logic one_pulse_mode;
    logic pwm_mode;
    logic capture_b_edge_select;
    logic capture_a_edge_select;
    logic ext_clock_edge_select;
    logic ext_clock_select;
  } control_one_t;

  typedef struct packed {
    logic capture_a_irq_enable;
    logic compare_a_irq_enable;
    logic overflow_irq_enable;
    logic capture_b_irq_enable;
    logic compare_b_irq_enable;
    logic [2:0] reserved;
    logic [7:0] prescale_factor;
  } control_two_t;

  typedef struct packed {
    logic capture_a_flag;
    logic compare_a_flag;
    logic overflow_flag;
    logic capture_b_flag;
    logic compare_b_flag;
    logic [10:0] reserved;
  } event_flags_t;

  typedef struct packed {
    logic capture_a;
    logic compare_a;
    logic overflow;
    logic capture_b;
    logic compare_b;
  } irq_lines_t;

endpackage

// *** verilog/timer_capture_compare_pwm.sv ***
// Design of the 16-bit capture/compare/PWM timer with its register port
// Operation
// - Compare A value, reset 8000h, matched against counter, drives compare A pin.
// - Compare B value, reset 8000h, matched against counter, drives compare B pin.
// - Counter reads current count; any write forces FFFCh; resets to FFFCh.
// - Control bit 15 gates counting; cleared holds the counter except on writes and capture A restarts.
// - Control bit 14 enables pulse measurement using capture pin A and both captures.
// - Writing 1 to control bit 11 drives output level B onto pin B.
// - Writing 1 to control bit 10 drives output level A onto pin A.
// - Output level B goes to pin B on match B; pin A in pulse/PWM modes.
// - Output level A goes to pin A on compare A match when dedicated.
// - Control bit 7 dedicates compare B pin to the timer.
// - Control bit 6 dedicates compare A pin to the timer.
// - Control bit 5: capture A edge triggers one pulse, length from compare A.
// - Control bit 4: PWM on pin A, pulse from compare A, period compare B.
// - Bits 3 and 2 pick capture edge for B and A; 1 rising.
// - Bit 1 picks external clock edge; 1 rising, 0 falling.
// - Bit 0 picks clock source: prescaled internal or external clock.
// - Second-control bits 15..11 enable five requests, each flag AND enable.
// - Prescale factor bits 7:0 divide internal clock by factor plus one.
// - Capture flags set on capture events, capture A's not on the first measuring edge; writing 0 clears, 1 keeps.
// - Compare A flag sets on match A, except in PWM and one-pulse modes.
// - Overflow flag sets on wrap FFFFh to 0000h; cleared by writing 0.
// - Compare B flag sets on match B, PWM mode included.
// - In PWM mode a compare B match reloads the counter with FFFCh.
// - One-pulse trigger reloads FFFCh; level B on pin A four ticks later.
`timescale 1ns/10ps

module timer_capture_compare_pwm
  import timer_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // Capture and clock pins
  input wire logic capture_a_pin,
  input wire logic capture_b_pin,
  input wire logic external_count_clock,
  // Compare pins
  output logic compare_a_pin_out,
  output logic compare_a_pin_oe,
  output logic compare_b_pin_out,
  output logic compare_b_pin_oe,
  // Interrupt requests
  output irq_lines_t irq_req
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [15:0] compare_a_reg;
  logic [15:0] compare_b_reg;
  logic [15:0] counter_reg;
  logic [15:0] counter_next;
  logic [15:0] capture_a_reg;
  logic [15:0] capture_b_reg;
  control_one_t control_one_reg;
  control_two_t control_two_reg;
  event_flags_t flags_reg;
  logic [7:0] presc_reg;
  logic cap_a_prev_reg;
  logic cap_b_prev_reg;
  logic ext_prev_reg;
  logic opm_armed_reg;
  logic measure_primed_reg;
  logic pin_a_reg;
  logic pin_b_reg;
  logic pin_a_oe_reg;
  logic pin_b_oe_reg;
  irq_lines_t irq_reg;
  logic [15:0] rdata_reg;

  // ****************************************************************
  // Decode and events
  // ****************************************************************
  logic wr_compare_a, wr_compare_b, wr_counter, wr_ctl_one, wr_ctl_two, wr_flags;
  logic presc_tick, ext_edge, tick;
  logic cap_a_edge, cap_b_src, cap_b_src_prev, cap_b_edge;
  logic match_a, match_b, wrap;
  logic opm_act, pwm_act;
  logic force_a_now, force_b_now;
  control_one_t wr_ctl;

  assign wr_compare_a = reg_wr_en && (reg_addr == OFF_COMPARE_A);
  assign wr_compare_b = reg_wr_en && (reg_addr == OFF_COMPARE_B);
  assign wr_counter = reg_wr_en && (reg_addr == OFF_COUNTER);
  assign wr_ctl_one = reg_wr_en && (reg_addr == OFF_CONTROL_ONE);
  assign wr_ctl_two = reg_wr_en && (reg_addr == OFF_CONTROL_TWO);
  assign wr_flags = reg_wr_en && (reg_addr == OFF_EVENT_FLAGS);
  assign wr_ctl = control_one_t'(reg_wdata);

  // Forcing is an action of the write itself, taken with the levels written alongside
  assign force_a_now = wr_ctl_one && wr_ctl.force_level_a;
  assign force_b_now = wr_ctl_one && wr_ctl.force_level_b;

  assign presc_tick = (presc_reg == control_two_reg.prescale_factor);
  assign ext_edge = control_one_reg.ext_clock_edge_select ? (external_count_clock && !ext_prev_reg)
                                                          : (!external_count_clock && ext_prev_reg);
  assign tick = control_one_reg.enable && (control_one_reg.ext_clock_select ? ext_edge : presc_tick);

  assign cap_a_edge = control_one_reg.capture_a_edge_select ? (capture_a_pin && !cap_a_prev_reg)
                                                            : (!capture_a_pin && cap_a_prev_reg);
  // Pulse measurement takes both captures from pin A
  assign cap_b_src = control_one_reg.pulse_measure_mode ? capture_a_pin : capture_b_pin;
  assign cap_b_src_prev = control_one_reg.pulse_measure_mode ? cap_a_prev_reg : cap_b_prev_reg;
  assign cap_b_edge = control_one_reg.capture_b_edge_select ? (cap_b_src && !cap_b_src_prev)
                                                            : (!cap_b_src && cap_b_src_prev);

  // With both modes set, forcing A selects one-pulse, otherwise PWM wins
  assign opm_act = control_one_reg.one_pulse_mode && (!control_one_reg.pwm_mode || control_one_reg.force_level_a);
  assign pwm_act = control_one_reg.pwm_mode && !opm_act;

  assign match_a = tick && (counter_reg == compare_a_reg);
  assign match_b = tick && (counter_reg == compare_b_reg);
  assign wrap = tick && (counter_reg == COUNTER_MAX) && !(pwm_act && match_b);

  // ****************************************************************
  // Counter and prescaler
  // ****************************************************************
  always_comb begin
    counter_next = counter_reg;
    if (wr_counter) begin
      counter_next = COUNTER_RELOAD;
    end else if (opm_act && cap_a_edge) begin
      counter_next = COUNTER_RELOAD;
    end else if (control_one_reg.pulse_measure_mode && cap_a_edge) begin
      counter_next = COUNTER_ZERO;
    end else if (tick) begin
      if (pwm_act && match_b) begin
        counter_next = COUNTER_RELOAD;
      end else begin
        counter_next = counter_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      counter_reg <= COUNTER_RELOAD;
    end else begin
      counter_reg <= counter_next;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      presc_reg <= PRESCALE_RESET;
    end else if (!control_one_reg.enable || presc_tick) begin
      presc_reg <= PRESCALE_RESET;
    end else begin
      presc_reg <= presc_reg + 8'h01;
    end
  end

  // Inputs are synchronous; one stage of history is enough for edge detection
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cap_a_prev_reg <= 1'b0;
      cap_b_prev_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end else begin
      cap_a_prev_reg <= capture_a_pin;
      cap_b_prev_reg <= capture_b_pin;
      ext_prev_reg <= external_count_clock;
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      compare_a_reg <= COMPARE_RESET;
      compare_b_reg <= COMPARE_RESET;
    end else begin
      if (wr_compare_a) begin
        compare_a_reg <= reg_wdata;
      end
      if (wr_compare_b) begin
        compare_b_reg <= reg_wdata;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      control_one_reg <= control_one_t'(CONTROL_RESET);
      control_two_reg <= control_two_t'(CONTROL_RESET);
    end else begin
      if (wr_ctl_one) begin
        control_one_reg <= wr_ctl;
        control_one_reg.reserved <= 2'h0;
      end
      if (wr_ctl_two) begin
        control_two_reg <= control_two_t'(reg_wdata);
        control_two_reg.reserved <= 3'h0;
      end
    end
  end

  // ****************************************************************
  // Captures and pulse measurement
  // ****************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      capture_a_reg <= CAPTURE_RESET;
      capture_b_reg <= CAPTURE_RESET;
    end else begin
      if (cap_a_edge) begin
        capture_a_reg <= counter_reg;
      end
      if (cap_b_edge) begin
        capture_b_reg <= counter_reg;
      end
    end
  end

  // The first measuring edge only starts the count, so it raises no capture A flag
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      measure_primed_reg <= 1'b0;
    end else if (!control_one_reg.pulse_measure_mode) begin
      measure_primed_reg <= 1'b0;
    end else if (cap_a_edge) begin
      measure_primed_reg <= 1'b1;
    end
  end

  // ****************************************************************
  // Event flags: hardware set wins over a software clear
  // ****************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flags_reg <= event_flags_t'(FLAGS_RESET);
    end else begin
      flags_reg.capture_a_flag <= (cap_a_edge && (!control_one_reg.pulse_measure_mode || measure_primed_reg))
                                  || (flags_reg.capture_a_flag && !(wr_flags && !reg_wdata[15]));
      flags_reg.compare_a_flag <= (match_a && !pwm_act && !opm_act)
                                  || (flags_reg.compare_a_flag && !(wr_flags && !reg_wdata[14]));
      flags_reg.overflow_flag <= wrap
                                 || (flags_reg.overflow_flag && !(wr_flags && !reg_wdata[13]));
      flags_reg.capture_b_flag <= cap_b_edge
                                  || (flags_reg.capture_b_flag && !(wr_flags && !reg_wdata[12]));
      flags_reg.compare_b_flag <= match_b
                                  || (flags_reg.compare_b_flag && !(wr_flags && !reg_wdata[11]));
      flags_reg.reserved <= 11'h000;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_reg <= irq_lines_t'(5'h00);
    end else begin
      irq_reg.capture_a <= flags_reg.capture_a_flag && control_two_reg.capture_a_irq_enable;
      irq_reg.compare_a <= flags_reg.compare_a_flag && control_two_reg.compare_a_irq_enable;
      irq_reg.overflow <= flags_reg.overflow_flag && control_two_reg.overflow_irq_enable;
      irq_reg.capture_b <= flags_reg.capture_b_flag && control_two_reg.capture_b_irq_enable;
      irq_reg.compare_b <= flags_reg.compare_b_flag && control_two_reg.compare_b_irq_enable;
    end
  end

  // ****************************************************************
  // Compare pins
  // ****************************************************************
  // One-pulse: level B appears when FFFCh has stepped up to 0000h, four ticks on
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      opm_armed_reg <= 1'b0;
    end else if (!opm_act) begin
      opm_armed_reg <= 1'b0;
    end else if (cap_a_edge) begin
      opm_armed_reg <= 1'b1;
    end else if (tick && (counter_reg == COUNTER_MAX)) begin
      opm_armed_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_a_reg <= 1'b0;
    end else if (force_a_now) begin
      pin_a_reg <= wr_ctl.output_level_a;
    end else if (opm_act && opm_armed_reg && !cap_a_edge && tick && (counter_reg == COUNTER_MAX)) begin
      pin_a_reg <= control_one_reg.output_level_b;
    end else if (pwm_act && match_b) begin
      pin_a_reg <= control_one_reg.output_level_b;
    end else if (match_a) begin
      pin_a_reg <= control_one_reg.output_level_a;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_b_reg <= 1'b0;
    end else if (force_b_now) begin
      pin_b_reg <= wr_ctl.output_level_b;
    end else if (match_b && !pwm_act && !opm_act) begin
      pin_b_reg <= control_one_reg.output_level_b;
    end
  end

  // Undedicated pins stay general I/O, so the timer releases them
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_a_oe_reg <= 1'b0;
      pin_b_oe_reg <= 1'b0;
    end else begin
      pin_a_oe_reg <= control_one_reg.compare_a_pin_dedicate;
      pin_b_oe_reg <= control_one_reg.compare_b_pin_dedicate;
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 16'h0000;
    end else if (reg_rd_en) begin
      case (reg_addr)
        OFF_CAPTURE_A: rdata_reg <= capture_a_reg;
        OFF_CAPTURE_B: rdata_reg <= capture_b_reg;
        OFF_COMPARE_A: rdata_reg <= compare_a_reg;
        OFF_COMPARE_B: rdata_reg <= compare_b_reg;
        OFF_COUNTER: rdata_reg <= counter_reg;
        OFF_CONTROL_ONE: rdata_reg <= control_one_reg;
        OFF_CONTROL_TWO: rdata_reg <= control_two_reg;
        OFF_EVENT_FLAGS: rdata_reg <= flags_reg;
        default: rdata_reg <= 16'h0000;
      endcase
    end
  end

  assign reg_rdata = rdata_reg;
  assign compare_a_pin_out = pin_a_reg;
  assign compare_a_pin_oe = pin_a_oe_reg;
  assign compare_b_pin_out = pin_b_reg;
  assign compare_b_pin_oe = pin_b_oe_reg;
  assign irq_req = irq_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  counter_write_reload_a: assert property (wr_counter |=> counter_reg == COUNTER_RELOAD)
    else $error("counter write did not reload FFFCh");
  counter_hold_a: assert property (!control_one_reg.enable && !wr_counter && !cap_a_edge
                                   |=> $stable(counter_reg))
    else $error("disabled counter moved");
  counter_step_a: assert property (tick && !wr_counter && !cap_a_edge && !(pwm_act && match_b)
                                   |=> counter_reg == $past(counter_reg) + 16'h0001)
    else $error("counter did not step by one");
  pwm_reload_a: assert property (pwm_act && match_b && !wr_counter && !cap_a_edge && !force_a_now
                                 |=> counter_reg == COUNTER_RELOAD
                                     && pin_a_reg == $past(control_one_reg.output_level_b))
    else $error("PWM period end mishandled");
  compare_a_level_a: assert property (match_a && !force_a_now && !pwm_act && !opm_act
                                      |=> pin_a_reg == $past(control_one_reg.output_level_a))
    else $error("pin A level wrong after match");
  force_b_level_a: assert property (force_b_now |=> pin_b_reg == $past(reg_wdata[9]))
    else $error("force B did not drive level B");
  overflow_flag_a: assert property (wrap |=> flags_reg.overflow_flag)
    else $error("overflow flag not set on wrap");
  set_beats_clear_a: assert property (match_b && wr_flags && !reg_wdata[11] |=> flags_reg.compare_b_flag)
    else $error("compare B event lost on clear");
  flag_clear_a: assert property (wr_flags && !reg_wdata[15] && !cap_a_edge |=> !flags_reg.capture_a_flag)
    else $error("capture A flag not cleared");
  pwm_no_cmpa_a: assert property (pwm_act && !flags_reg.compare_a_flag ##1 pwm_act
                                  |-> !flags_reg.compare_a_flag || !$past(pwm_act))
    else $error("compare A flag set in PWM mode");
  irq_follow_a: assert property (flags_reg.compare_b_flag && control_two_reg.compare_b_irq_enable
                                 |=> irq_reg.compare_b)
    else $error("compare B request missing");
  opm_delay_a: assert property (opm_act && cap_a_edge && !wr_counter |=> counter_reg == COUNTER_RELOAD)
    else $error("one-pulse trigger did not reload");
  oe_follow_a: assert property (##1 compare_a_pin_oe == $past(control_one_reg.compare_a_pin_dedicate))
    else $error("pin A enable does not follow dedicate bit");

  pwm_cycle_c: cover property (pwm_act && match_b ##[1:1000] pwm_act && match_a);
  opm_pulse_c: cover property (opm_act && cap_a_edge ##[1:1000] match_a);
  measure_c: cover property (control_one_reg.pulse_measure_mode && cap_a_edge && measure_primed_reg);
  wrap_c: cover property (wrap);

endmodule // timer_capture_compare_pwm

// *** tb/capture_source.sv ***
// Far-side model driving the capture pins and the external count clock
`timescale 1ns/10ps

module capture_source (
  // Clock
  input wire logic core_clk,
  // Pins toward the timer
  output logic capture_a_pin,
  output logic capture_b_pin,
  output logic external_count_clock
);
  initial begin
    capture_a_pin = 1'b0;
    capture_b_pin = 1'b0;
    external_count_clock = 1'b0;
  end

  // Each level is held four clocks so the timer sees every edge exactly once
  task automatic toggle(input int which, input int times);
    repeat (times) begin
      @(negedge core_clk);
      case (which)
        0: capture_a_pin = ~capture_a_pin;
        1: capture_b_pin = ~capture_b_pin;
        default: external_count_clock = ~external_count_clock;
      endcase
      repeat (3) @(negedge core_clk);
    end
  endtask
endmodule // capture_source

// *** tb/tb_top.sv ***
// Self-checking bench of the capture/compare/PWM timer
`timescale 1ns/10ps

module tb_top;
  import timer_pkg::*;
  logic core_clk, rst, reg_wr_en, reg_rd_en, rd_taken;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rand_a, rand_b;
  logic capture_a_pin, capture_b_pin, external_count_clock;
  logic compare_a_pin_out, compare_a_pin_oe, compare_b_pin_out, compare_b_pin_oe;
  irq_lines_t irq_req;
  logic [31:0] seed = 32'h96033D16;
  int mismatches = 0;
  int tests_run = 0;
  logic [15:0] exp_q[$];
  string name_q[$];
  logic [4:0] offs[7] = '{OFF_COMPARE_A, OFF_COMPARE_B, OFF_COUNTER, OFF_CONTROL_ONE, OFF_CONTROL_TWO,
                          OFF_EVENT_FLAGS, 5'h1E};
  logic [15:0] rsts[7] = '{COMPARE_RESET, COMPARE_RESET, COUNTER_RELOAD, CONTROL_RESET, CONTROL_RESET,
                           FLAGS_RESET, 16'h0000};

  timer_capture_compare_pwm DUT (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .capture_a_pin(capture_a_pin),
    .capture_b_pin(capture_b_pin), .external_count_clock(external_count_clock),
    .compare_a_pin_out(compare_a_pin_out), .compare_a_pin_oe(compare_a_pin_oe),
    .compare_b_pin_out(compare_b_pin_out), .compare_b_pin_oe(compare_b_pin_oe), .irq_req(irq_req));
  capture_source far_side (.core_clk(core_clk), .capture_a_pin(capture_a_pin), .capture_b_pin(capture_b_pin),
    .external_count_clock(external_count_clock));

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp_v);
    tests_run++;
    if (seen !== exp_v) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp_v, seen);
    end
  endtask

  task automatic summarize();
    if (mismatches == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
  endtask

  // Each read leaves its expectation for the watcher
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    exp_q.push_back(e);
    name_q.push_back($sformatf("register %h", a));
    @(negedge core_clk);
    reg_rd_en = 1'b0;
  endtask

  // ****************************************************************
  // Clock, watcher and watchdog
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) rd_taken <= reg_rd_en;

  always @(negedge core_clk) begin
    if (rd_taken && exp_q.size() > 0) check(name_q.pop_front(), reg_rdata, exp_q.pop_front());
  end

  initial begin
    #20000;
    mismatches++;
    summarize();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    rst = 1'b1;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    for (int i = 0; i < 7; i++) rd(offs[i], rsts[i]);
    seed = xorshift(seed);
    rand_a = {1'b0, seed[14:0]} | 16'h0010;
    seed = xorshift(seed);
    rand_b = {1'b0, seed[14:0]} | 16'h0010;
    wr(OFF_COMPARE_A, rand_a);
    wr(OFF_COMPARE_B, rand_b);
    wr(OFF_COUNTER, seed[31:16]);
    wr(OFF_CONTROL_ONE, 16'h3000);
    rd(OFF_COMPARE_A, rand_a);
    rd(OFF_COMPARE_B, rand_b);
    rd(OFF_COUNTER, COUNTER_RELOAD);
    rd(OFF_CONTROL_ONE, 16'h0000);
    // External edges: three rising, then one falling wraps to zero
    wr(OFF_CONTROL_TWO, 16'hF800);
    wr(OFF_CONTROL_ONE, 16'h8003);
    far_side.toggle(2, 6);
    wr(OFF_CONTROL_ONE, 16'h0000);
    rd(OFF_COUNTER, 16'hFFFF);
    wr(OFF_CONTROL_ONE, 16'h8001);
    far_side.toggle(2, 2);
    wr(OFF_CONTROL_ONE, 16'h0000);
    rd(OFF_COUNTER, 16'h0000);
    rd(OFF_EVENT_FLAGS, 16'h2000);
    check("overflow request", {15'h0, irq_req.overflow}, 16'h0001);
    wr(OFF_EVENT_FLAGS, 16'hDFFF);
    rd(OFF_EVENT_FLAGS, 16'h0000);
    check("overflow request", {15'h0, irq_req.overflow}, 16'h0000);
    // Compare A match on a dedicated pin, then forced levels
    wr(OFF_COMPARE_A, 16'h0001);
    wr(OFF_COMPARE_B, 16'h4000);
    wr(OFF_CONTROL_ONE, 16'h8143);
    far_side.toggle(2, 4);
    wr(OFF_CONTROL_ONE, 16'h0040);
    rd(OFF_EVENT_FLAGS, 16'h4000);
    check("pin a level", {14'h0, compare_a_pin_oe, compare_a_pin_out}, 16'h0003);
    wr(OFF_CONTROL_ONE, 16'h0440);
    wr(OFF_CONTROL_ONE, 16'h0A80);
    repeat (2) @(negedge core_clk);
    check("pin a forced", {14'h0, compare_a_pin_oe, compare_a_pin_out}, 16'h0000);
    check("pin b forced", {14'h0, compare_b_pin_oe, compare_b_pin_out}, 16'h0003);
    // Captures: A on rising, B on falling
    wr(OFF_EVENT_FLAGS, 16'h0000);
    wr(OFF_CONTROL_ONE, 16'h0004);
    far_side.toggle(0, 1);
    far_side.toggle(1, 2);
    rd(OFF_EVENT_FLAGS, 16'h9000);
    check("capture requests", {11'h0, irq_req}, 16'h0012);
    // PWM: match B at FFFF reloads FFFC without overflow
    wr(OFF_EVENT_FLAGS, 16'h0000);
    wr(OFF_COMPARE_A, 16'hFFFD);
    wr(OFF_COMPARE_B, 16'hFFFF);
    wr(OFF_COUNTER, 16'h0000);
    wr(OFF_CONTROL_ONE, 16'h8157);
    far_side.toggle(2, 6);
    check("pwm high", {15'h0, compare_a_pin_out}, 16'h0001);
    far_side.toggle(2, 2);
    check("pwm low", {15'h0, compare_a_pin_out}, 16'h0000);
    wr(OFF_CONTROL_ONE, 16'h0000);
    rd(OFF_COUNTER, COUNTER_RELOAD);
    rd(OFF_EVENT_FLAGS, 16'h0800);
    // One pulse: falling A edge restarts at FFFC, level B reaches pin A four ticks later
    wr(OFF_EVENT_FLAGS, 16'h0000);
    wr(OFF_COMPARE_A, 16'h0002);
    wr(OFF_CONTROL_ONE, 16'h8263);
    far_side.toggle(0, 1);
    far_side.toggle(2, 8);
    check("pulse start", {15'h0, compare_a_pin_out}, 16'h0001);
    far_side.toggle(2, 6);
    check("pulse end", {15'h0, compare_a_pin_out}, 16'h0000);
    wr(OFF_CONTROL_ONE, 16'h0000);
    rd(OFF_COUNTER, 16'h0003);
    rd(OFF_EVENT_FLAGS, 16'hA800);
    // Pulse measurement: the first rising A edge only restarts the count
    wr(OFF_EVENT_FLAGS, 16'h0000);
    wr(OFF_CONTROL_ONE, 16'h4004);
    far_side.toggle(0, 2);
    rd(OFF_EVENT_FLAGS, 16'h1000);
    far_side.toggle(0, 1);
    rd(OFF_EVENT_FLAGS, 16'h9000);
    rd(OFF_COUNTER, 16'h0000);
    // Prescaler of four: exactly ten ticks while enabled for forty-two clocks
    wr(OFF_COUNTER, 16'h1234);
    wr(OFF_CONTROL_TWO, 16'h0003);
    wr(OFF_CONTROL_ONE, 16'h8000);
    repeat (40) @(negedge core_clk);
    wr(OFF_CONTROL_ONE, 16'h0000);
    rd(OFF_COUNTER, COUNTER_RELOAD + 16'h000A);
    summarize();
  end
endmodule // tb_top
